// [pkg/lsq_pkg.sv]
// Package for the regulator sequence and soft-start configuration block.
// Assumes a single 100 MHz clock and an I2C register port.
package lsq_pkg;

  // Clock
  localparam int CLK_PERIOD_NS = 10;

  // Register byte addresses
  localparam logic [7:0] ADDR_PRIO_A  = 8'h2e;
  localparam logic [7:0] ADDR_PRIO_B  = 8'h2f;
  localparam logic [7:0] ADDR_PRIO_C  = 8'h30;
  localparam logic [7:0] ADDR_PRIO_D  = 8'h31;
  localparam logic [7:0] ADDR_SS_CTRL = 8'h32;

  // Field positions
  localparam int PRIO_LO_LSB = 0;
  localparam int PRIO_HI_LSB = 4;
  localparam int SS_SEL_LSB  = 2;
  localparam int SS_VOLT_LSB = 0;

  // Values after reset
  localparam logic [3:0] PRIO_RST    = 4'h0;
  localparam logic [3:0] SS_SEL_RST  = 4'h0;
  localparam logic [1:0] SS_VOLT_RST = 2'h0;

  // Priority codes
  localparam logic [3:0] PRIO_OFF   = 4'h0;
  localparam logic [3:0] PRIO_FIRST = 4'h1;
  localparam logic [3:0] PRIO_LAST  = 4'hc;

  // Soft-start end selector codes
  localparam logic [3:0] SEL_FIRST_ON  = 4'h0;
  localparam logic [3:0] SEL_BUCK1_ALT = 4'h4;
  localparam logic [3:0] SEL_REG1      = 4'h5;
  localparam logic [3:0] SEL_REG8      = 4'hc;

  // Channel codes for the power-good delay source
  localparam logic [3:0] SRC_BUCK1 = 4'h0;
  localparam logic [3:0] SRC_REG8  = 4'hb;
  localparam logic [3:0] SRC_NONE  = 4'hf;

  // Sequence step time and its cycle count (rounded up)
  localparam int SEQ_STEP_NS  = 1000;
  localparam int SEQ_STEP_CYC =
    (SEQ_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TMR_W = 8;

  // I2C slave address, arbitrary value
  localparam logic [6:0] I2C_DEV_ADDR = 7'h2a;
  localparam logic [3:0] I2C_BITS     = 4'h8;

  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_ACK_A, I2C_WR, I2C_ACK_W, I2C_RD, I2C_RACK
  } lsq_i2c_st_t;

  typedef enum logic [1:0] {
    SEQ_OFF, SEQ_UP, SEQ_ON, SEQ_DOWN
  } lsq_seq_st_t;

endpackage

// [rtl/lsq_i2c_slave.sv]
// I2C slave with byte pointer and auto-increment, oversampled on i_clk.
// Assumes SCL and SDA pins are asynchronous; open-drain SDA resolved outside.
`timescale 1ns/100ps
`default_nettype none
module lsq_i2c_slave (
  input  wire logic       i_clk,    // System clock
  input  wire logic       i_rst,    // Sync reset, high
  input  wire logic       i_ce,     // Clock enable
  input  wire logic       i_scl,    // SCL pin level
  input  wire logic       i_sda,    // SDA pin level
  output logic            o_sda,    // SDA drive value
  output logic            o_sda_oe, // SDA enable, high pulls low
  output logic            o_wr,     // Write strobe, one cycle
  output logic [7:0]      o_addr,   // Register pointer
  output logic [7:0]      o_wdata,  // Write data
  input  wire logic [7:0] i_rdata   // Read data at o_addr
);

  logic [1:0]          scl_sync;
  logic [1:0]          sda_sync;
  logic                scl_q;
  logic                sda_q;
  lsq_pkg::lsq_i2c_st_t state;
  logic [3:0]          cnt;
  logic [7:0]          shreg;
  logic                rw;
  logic                first;
  logic                inc_pend;
  logic                nack;

  // Edge and condition detection on synchronised pins
  wire scl       = scl_sync[1];
  wire sda       = sda_sync[1];
  wire scl_rise  = scl & ~scl_q;
  wire scl_fall  = ~scl & scl_q;
  wire bus_start = scl & scl_q & sda_q & ~sda;
  wire bus_stop  = scl & scl_q & ~sda_q & sda;
  wire byte_done = scl_fall && (cnt == lsq_pkg::I2C_BITS);

  // Pin synchronisers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
    end else if (i_ce) begin
      scl_sync <= {scl_sync[0], i_scl};
      sda_sync <= {sda_sync[0], i_sda};
      scl_q    <= scl_sync[1];
      sda_q    <= sda_sync[1];
    end
  end

  // Protocol state machine
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state    <= lsq_pkg::I2C_IDLE;
      cnt      <= 4'h0;
      shreg    <= 8'h00;
      rw       <= 1'b0;
      first    <= 1'b1;
      inc_pend <= 1'b0;
      nack     <= 1'b0;
      o_sda    <= 1'b0;
      o_sda_oe <= 1'b0;
      o_wr     <= 1'b0;
      o_addr   <= 8'h00;
      o_wdata  <= 8'h00;
    end else if (i_ce) begin
      o_wr <= 1'b0;
      if (bus_start) begin
        state    <= lsq_pkg::I2C_ADDR;
        cnt      <= 4'h0;
        first    <= 1'b1;
        o_sda_oe <= 1'b0;
      end else if (bus_stop) begin
        state    <= lsq_pkg::I2C_IDLE;
        o_sda_oe <= 1'b0;
      end else begin
        case (state)
          lsq_pkg::I2C_ADDR, lsq_pkg::I2C_WR: begin
            if (scl_rise) begin
              shreg <= {shreg[6:0], sda};
              cnt   <= cnt + 4'h1;
            end else if (byte_done) begin
              cnt <= 4'h0;
              if (state == lsq_pkg::I2C_ADDR) begin
                if (shreg[7:1] == lsq_pkg::I2C_DEV_ADDR) begin
                  rw       <= shreg[0];
                  o_sda_oe <= 1'b1;
                  state    <= lsq_pkg::I2C_ACK_A;
                end else begin
                  state <= lsq_pkg::I2C_IDLE;
                end
              end else begin
                o_sda_oe <= 1'b1;
                state    <= lsq_pkg::I2C_ACK_W;
                first    <= 1'b0;
                if (first) begin
                  o_addr <= shreg;
                end else begin
                  o_wr     <= 1'b1;
                  o_wdata  <= shreg;
                  inc_pend <= 1'b1;
                end
              end
            end
          end
          lsq_pkg::I2C_ACK_A, lsq_pkg::I2C_RACK: begin
            if (scl_rise) begin
              nack <= sda;
            end else if (scl_fall) begin
              if (state == lsq_pkg::I2C_RACK && nack) begin
                o_sda_oe <= 1'b0;
                state    <= lsq_pkg::I2C_IDLE;
              end else if (state == lsq_pkg::I2C_RACK || rw) begin
                shreg    <= i_rdata;
                o_sda_oe <= ~i_rdata[7];
                cnt      <= 4'h1;
                state    <= lsq_pkg::I2C_RD;
              end else begin
                o_sda_oe <= 1'b0;
                state    <= lsq_pkg::I2C_WR;
              end
            end
          end
          lsq_pkg::I2C_ACK_W: begin
            if (scl_fall) begin
              o_sda_oe <= 1'b0;
              state    <= lsq_pkg::I2C_WR;
              inc_pend <= 1'b0;
              if (inc_pend) begin
                o_addr <= o_addr + 8'h01;
              end
            end
          end
          lsq_pkg::I2C_RD: begin
            if (byte_done) begin
              o_sda_oe <= 1'b0;
              state    <= lsq_pkg::I2C_RACK;
              o_addr   <= o_addr + 8'h01;
            end else if (scl_fall) begin
              o_sda_oe <= ~shreg[6];
              shreg    <= {shreg[6:0], 1'b0};
              cnt      <= cnt + 4'h1;
            end
          end
          lsq_pkg::I2C_IDLE: begin
            o_sda_oe <= 1'b0;
          end
          default: begin
            state <= lsq_pkg::I2C_IDLE;
          end
        endcase
      end
    end
  end

endmodule
`default_nettype wire

// [rtl/lsq_seq_cfg.sv]
// Regulator sequence priorities, soft-start end selection and sequencer.
// Assumes I2C and control pins are asynchronous to i_clk.
//
// Notes on behaviour
// - Register 0x2e holds regulator one priority in [3:0], two in [7:4].
// - Register 0x2f holds regulator three in [3:0], four in [7:4].
// - Register 0x30 holds regulator five in [3:0], six in [7:4].
// - Register 0x31 holds regulator seven in [3:0], eight in [7:4].
// - Code 0 keeps a regulator off, 1 turns it on first, 12 on last.
// - Power-down walks the steps in reverse, so first on is last off.
// - With enable-source pin low, bits [5:2] of 0x32 pick the channel.
// - Selector 1 and selector 4 both pick buck converter one.
// - Selector 5 picks regulator one and selector 12 regulator eight.
// - Selectors 13 to 15 also pick regulator eight.
`timescale 1ns/100ps
`default_nettype none
module lsq_seq_cfg (
  input  wire logic i_clk,          // System clock
  input  wire logic i_rst,          // Sync reset, high
  input  wire logic i_ce,           // Clock enable
  input  wire logic i_scl,          // I2C clock pin
  input  wire logic i_sda,          // I2C data pin level
  output logic      o_sda,          // I2C data drive value
  output logic      o_sda_oe,       // I2C data enable, pulls low
  input  wire logic i_pwr_req,      // Power request pin, high = up
  input  wire logic i_en_src_sel,   // Enable source pin, low = ext pins
  output logic [7:0] o_reg_en,      // Regulator enables
  output logic       o_seq_busy,    // Sequencer stepping
  output logic       o_seq_on,      // Sequence fully up
  output logic [3:0] o_pgd_src,     // Channel setting power-good delay
  output logic       o_pgd_active,  // Selector applies
  output logic [1:0] o_ss_volt      // Soft-start level/time setting
);

  logic [3:0]           prio [8];
  logic [3:0]           ss_sel;
  logic [1:0]           ss_volt;
  logic [1:0]           req_sync;
  logic [1:0]           src_sync;
  lsq_pkg::lsq_seq_st_t seq_st;
  logic [3:0]           step;
  logic [lsq_pkg::TMR_W-1:0] tmr;
  logic                 bus_wr;
  logic [7:0]           bus_addr;
  logic [7:0]           bus_wdata;
  logic [7:0]           rd_data;

  // Byte address of the register holding a channel's priority
  function automatic logic [7:0] prio_addr(input int ch);
    prio_addr = lsq_pkg::ADDR_PRIO_A + 8'(ch / 2);
  endfunction

  // Earliest sequenced channel, lowest index on a tie
  function automatic logic [3:0] first_on(input logic [31:0] p);
    logic [3:0] best;
    logic [3:0] code;
    first_on = lsq_pkg::SRC_NONE;
    best     = 4'hf;
    for (int i = 0; i < 8; i++) begin
      code = p[4*i +: 4];
      if (code != lsq_pkg::PRIO_OFF && code <= lsq_pkg::PRIO_LAST &&
          code < best) begin
        best     = code;
        first_on = lsq_pkg::SRC_BUCK1 + 4'(4 + i);
      end
    end
  endfunction

  // Register port
  lsq_i2c_slave u_i2c (
    .i_clk    (i_clk),
    .i_rst    (i_rst),
    .i_ce     (i_ce),
    .i_scl    (i_scl),
    .i_sda    (i_sda),
    .o_sda    (o_sda),
    .o_sda_oe (o_sda_oe),
    .o_wr     (bus_wr),
    .o_addr   (bus_addr),
    .o_wdata  (bus_wdata),
    .i_rdata  (rd_data)
  );

  // Read selection, reserved and unmapped bits read zero
  wire [7:0] rd_prio_a = {prio[1], prio[0]};
  wire [7:0] rd_prio_b = {prio[3], prio[2]};
  wire [7:0] rd_prio_c = {prio[5], prio[4]};
  wire [7:0] rd_prio_d = {prio[7], prio[6]};
  wire [7:0] rd_ss     = {2'h0, ss_sel, ss_volt};
  assign rd_data =
    (bus_addr == prio_addr(0))          ? rd_prio_a :
    (bus_addr == prio_addr(2))          ? rd_prio_b :
    (bus_addr == prio_addr(4))          ? rd_prio_c :
    (bus_addr == prio_addr(6))          ? rd_prio_d :
    (bus_addr == lsq_pkg::ADDR_SS_CTRL) ? rd_ss     : 8'h00;

  // Priority and soft-start register writes
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      for (int i = 0; i < 8; i++) begin
        prio[i] <= lsq_pkg::PRIO_RST;
      end
      ss_sel  <= lsq_pkg::SS_SEL_RST;
      ss_volt <= lsq_pkg::SS_VOLT_RST;
    end else if (i_ce && bus_wr) begin
      for (int i = 0; i < 8; i++) begin
        if (bus_addr == prio_addr(i)) begin
          prio[i] <= (i % 2 == 1) ?
            bus_wdata[lsq_pkg::PRIO_HI_LSB +: 4] :
            bus_wdata[lsq_pkg::PRIO_LO_LSB +: 4];
        end
      end
      if (bus_addr == lsq_pkg::ADDR_SS_CTRL) begin
        ss_sel  <= bus_wdata[lsq_pkg::SS_SEL_LSB +: 4];
        ss_volt <= bus_wdata[lsq_pkg::SS_VOLT_LSB +: 2];
      end
    end
  end

  // Control pin synchronisers
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      req_sync <= 2'h0;
      src_sync <= 2'h3;
    end else if (i_ce) begin
      req_sync <= {req_sync[0], i_pwr_req};
      src_sync <= {src_sync[0], i_en_src_sel};
    end
  end

  // Power-good delay source decode
  wire [31:0] prio_flat = {prio[7], prio[6], prio[5], prio[4],
                           prio[3], prio[2], prio[1], prio[0]};
  wire        sel_first = (ss_sel == lsq_pkg::SEL_FIRST_ON);
  wire        sel_buck1 = (ss_sel == lsq_pkg::SEL_BUCK1_ALT);
  wire        sel_high  = (ss_sel > lsq_pkg::SEL_REG8);
  wire [3:0]  sel_lin   = ss_sel - 4'h1;
  wire [3:0]  next_pgd_src =
    sel_first ? first_on(prio_flat) :
    sel_buck1 ? lsq_pkg::SRC_BUCK1 :
    sel_high  ? lsq_pkg::SRC_REG8  :
                sel_lin;

  // Power-good source outputs
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_pgd_src    <= lsq_pkg::SRC_NONE;
      o_pgd_active <= 1'b0;
      o_ss_volt    <= lsq_pkg::SS_VOLT_RST;
    end else if (i_ce) begin
      o_pgd_src    <= next_pgd_src;
      o_pgd_active <= ~src_sync[1];
      o_ss_volt    <= ss_volt;
    end
  end

  // Step timing and step matching
  localparam logic [lsq_pkg::TMR_W-1:0] TMR_END =
    lsq_pkg::TMR_W'(lsq_pkg::SEQ_STEP_CYC - 1);
  wire       tmr_end  = (tmr == TMR_END);
  wire       tmr_zero = (tmr == '0);
  wire       req      = req_sync[1];
  logic [7:0] step_hit;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      step_hit[i] = (prio[i] == step) && (prio[i] != lsq_pkg::PRIO_OFF);
    end
  end

  // Sequencer: up through steps 1..12, down in reverse
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      seq_st     <= lsq_pkg::SEQ_OFF;
      step       <= lsq_pkg::PRIO_FIRST;
      tmr        <= '0;
      o_reg_en   <= 8'h00;
      o_seq_busy <= 1'b0;
      o_seq_on   <= 1'b0;
    end else if (i_ce) begin
      case (seq_st)
        lsq_pkg::SEQ_OFF: begin
          o_reg_en <= 8'h00;
          o_seq_on <= 1'b0;
          if (req) begin
            seq_st     <= lsq_pkg::SEQ_UP;
            step       <= lsq_pkg::PRIO_FIRST;
            tmr        <= '0;
            o_seq_busy <= 1'b1;
          end
        end
        lsq_pkg::SEQ_UP: begin
          if (tmr_zero) begin
            o_reg_en <= o_reg_en | step_hit;
          end
          if (!req) begin
            seq_st <= lsq_pkg::SEQ_DOWN;
            tmr    <= '0;
          end else if (!tmr_end) begin
            tmr <= tmr + lsq_pkg::TMR_W'(1);
          end else if (step == lsq_pkg::PRIO_LAST) begin
            seq_st     <= lsq_pkg::SEQ_ON;
            o_seq_busy <= 1'b0;
            o_seq_on   <= 1'b1;
          end else begin
            step <= step + 4'h1;
            tmr  <= '0;
          end
        end
        lsq_pkg::SEQ_ON: begin
          if (!req) begin
            seq_st     <= lsq_pkg::SEQ_DOWN;
            tmr        <= '0;
            o_seq_busy <= 1'b1;
            o_seq_on   <= 1'b0;
          end
        end
        lsq_pkg::SEQ_DOWN: begin
          if (tmr_zero) begin
            o_reg_en <= o_reg_en & ~step_hit;
          end
          if (req) begin
            seq_st <= lsq_pkg::SEQ_UP;
            tmr    <= '0;
          end else if (!tmr_end) begin
            tmr <= tmr + lsq_pkg::TMR_W'(1);
          end else if (step == lsq_pkg::PRIO_FIRST) begin
            seq_st     <= lsq_pkg::SEQ_OFF;
            o_seq_busy <= 1'b0;
          end else begin
            step <= step - 4'h1;
            tmr  <= '0;
          end
        end
        default: begin
          seq_st <= lsq_pkg::SEQ_OFF;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// [tb/lsq_seq_cfg_asserts.sv]
// Checker for the sequence and soft-start configuration block.
// Sees only the top ports; bound from the testbench top file.
`timescale 1ns/100ps
`default_nettype none
module lsq_seq_cfg_asserts (
  input  wire logic       i_clk,        // System clock
  input  wire logic       i_rst,        // Sync reset, high
  input  wire logic       i_ce,         // Clock enable
  input  wire logic       i_en_src_sel, // Enable source pin
  input  wire logic [7:0] o_reg_en,     // Regulator enables
  input  wire logic       o_seq_busy,   // Sequencer stepping
  input  wire logic       o_seq_on,     // Sequence fully up
  input  wire logic [3:0] o_pgd_src,    // Power-good delay channel
  input  wire logic       o_pgd_active  // Selector applies
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  logic [11:0] busy_cnt; // Cycles of the current stepping run

  // Length of a stepping run, cleared when idle
  always_ff @(posedge i_clk) begin
    if (i_rst || !o_seq_busy) begin
      busy_cnt <= 12'h000;
    end else begin
      busy_cnt <= busy_cnt + 12'h001;
    end
  end

  // End of a full power-up and of a full power-down
  sequence s_up_done;
    $rose(o_seq_on);
  endsequence
  sequence s_down_done;
    $fell(o_seq_busy) ##0 !o_seq_on;
  endsequence

  a_up_span: assert property (s_up_done |-> busy_cnt inside {[1190:1210]})
    else $error("Power-up run has wrong length");
  a_down_span: assert property (s_down_done |-> busy_cnt inside {[1190:1210]})
    else $error("Power-down run has wrong length");
  a_down_all_off: assert property (s_down_done |-> ##[0:1] o_reg_en == 8'h00)
    else $error("Enables left on after power-down");
  a_rise_in_up: assert property (|(o_reg_en & ~$past(o_reg_en))
    |-> $past(o_seq_busy) && !$past(o_seq_on))
    else $error("Enable set outside power-up");
  a_fall_in_down: assert property (|(~o_reg_en & $past(o_reg_en))
    |-> $past(o_seq_busy))
    else $error("Enable cleared outside power-down");
  a_on_idle: assert property (o_seq_on |-> !o_seq_busy && $stable(o_reg_en))
    else $error("Enables move while sequence is up");
  a_src_range: assert property (o_pgd_src <= 4'hb || o_pgd_src == 4'hf)
    else $error("Power-good source code out of range");
  a_pin_lag: assert property (!$past(i_rst, 1) && !$past(i_rst, 2)
    && !$past(i_rst, 3) && $past(i_ce, 1) && $past(i_ce, 2)
    && $past(i_ce, 3) |-> o_pgd_active == !$past(i_en_src_sel, 3))
    else $error("Selector apply flag does not follow pin");
endmodule
`default_nettype wire

// [tb/lsq_seq_cfg_tb.sv]
// Testbench for the sequence and soft-start configuration block.
// Acts as I2C master with a pull-up on SDA; one 100 MHz clock.
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin bad_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module lsq_seq_cfg_tb;
  logic       i_clk        = 1'b0;
  logic       i_rst        = 1'b1;
  logic       scl          = 1'b1;
  logic       sda_m        = 1'b1;
  logic       i_pwr_req    = 1'b0;
  logic       i_en_src_sel = 1'b0;
  logic       ce           = 1'b1;
  logic       o_sda, o_sda_oe, o_seq_busy, o_seq_on, o_pgd_active, ak;
  logic [7:0] o_reg_en, q, d, q2, ad;
  logic [3:0] o_pgd_src;
  logic [1:0] o_ss_volt;
  logic [3:0] pr [8];
  wire        sda_line;
  int         bad_count = 0, cmp_count = 0, cyc = 0, seed = 92723;

  // Open-drain SDA with pull-up
  assign sda_line = sda_m & (o_sda_oe ? o_sda : 1'b1);

  // Clock
  always #5 i_clk = ~i_clk;

  lsq_seq_cfg i_dut (
    .i_clk(i_clk), .i_rst(i_rst), .i_ce(ce), .i_scl(scl),
    .i_sda(sda_line), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
    .i_pwr_req(i_pwr_req), .i_en_src_sel(i_en_src_sel),
    .o_reg_en(o_reg_en), .o_seq_busy(o_seq_busy), .o_seq_on(o_seq_on),
    .o_pgd_src(o_pgd_src), .o_pgd_active(o_pgd_active),
    .o_ss_volt(o_ss_volt)
  );

  // Verdict and end of run
  task automatic end_sim;
    if (bad_count == 0 && cmp_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Hang guard
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 100000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic clk_n(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask

  // START (a=1,b=0) or STOP (a=0,b=1)
  task automatic frame(input logic a, input logic b);
    clk_n(3);
    sda_m = a;
    clk_n(7);
    scl = 1'b1;
    clk_n(5);
    sda_m = b;
    clk_n(5);
    scl = b;
  endtask

  // One bit, sampled mid SCL high
  task automatic bit_io(input logic b, output logic r);
    clk_n(3);
    sda_m = b;
    clk_n(7);
    scl = 1'b1;
    clk_n(5);
    r = sda_line;
    clk_n(5);
    scl = 1'b0;
  endtask

  task automatic xfer(input logic [7:0] v, input logic a,
                      output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--) bit_io(v[i], r[i]);
    bit_io(a, k);
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    frame(1'b1, 1'b0);
    xfer({lsq_pkg::I2C_DEV_ADDR, 1'b0}, 1'b1, q, ak);
    `CHK(ak, 1'b0)
    xfer(a, 1'b1, q, ak);
    xfer(v, 1'b1, q, ak);
    frame(1'b0, 1'b1);
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] v);
    frame(1'b1, 1'b0);
    xfer({lsq_pkg::I2C_DEV_ADDR, 1'b0}, 1'b1, q, ak);
    xfer(a, 1'b1, q, ak);
    frame(1'b1, 1'b0);
    xfer({lsq_pkg::I2C_DEV_ADDR, 1'b1}, 1'b1, q, ak);
    xfer(8'hff, 1'b1, v, ak);
    frame(1'b0, 1'b1);
  endtask

  task automatic set_prio;
    for (int j = 0; j < 4; j++)
      reg_wr(8'(lsq_pkg::ADDR_PRIO_A + j), {pr[2*j+1], pr[2*j]});
  endtask

  // Expected power-good source for a selector code
  function automatic logic [3:0] exp_src(input logic [3:0] s);
    logic [3:0] best;
    logic [3:0] src;
    best = 4'hd;
    src = lsq_pkg::SRC_NONE;
    if (s == 4'h0) begin
      for (int i = 0; i < 8; i++)
        if (pr[i] != 4'h0 && pr[i] < best) begin
          best = pr[i];
          src = 4'(i + 4);
        end
    end else if (s == 4'h1 || s == 4'h4) src = 4'h0;
    else if (s > 4'hc) src = 4'hb;
    else src = s - 4'h1;
    return src;
  endfunction

  // Expected enables once steps 1..k are done
  function automatic logic [7:0] exp_en(input int k);
    logic [7:0] e;
    for (int i = 0; i < 8; i++) e[i] = pr[i] != 4'h0 && int'(pr[i]) <= k;
    return e;
  endfunction

  // Main sequence
  initial begin
    clk_n(5);
    i_rst = 1'b0;
    clk_n(5);
    `CHK(o_pgd_src, lsq_pkg::SRC_NONE)
    `CHK(o_pgd_active, 1'b1)
    // Frozen block ignores pin and request changes
    ce = 1'b0;
    i_en_src_sel = 1'b1;
    i_pwr_req = 1'b1;
    clk_n(6);
    `CHK(o_pgd_active, 1'b1)
    `CHK(o_seq_busy, 1'b0)
    i_en_src_sel = 1'b0;
    i_pwr_req = 1'b0;
    ce = 1'b1;
    clk_n(4);
    for (int a = 0; a < 5; a++) begin
      reg_rd(8'(8'h2e + a), d);
      `CHK(d, 8'h00)
    end
    for (int a = 0; a < 6; a++) begin
      d = 8'($random(seed));
      ad = (a == 5) ? 8'h40 : 8'(8'h2e + a);
      reg_wr(ad, d);
      reg_rd(ad, q2);
      `CHK(q2, a == 5 ? 8'h00 : a == 4 ? d & 8'h3f : d)
      if (a == 4) `CHK(o_ss_volt, d[1:0])
    end
    for (int r = 0; r < 8; r++) pr[r] = 4'($random(seed));
    set_prio();
    for (int s = 0; s < 16; s++) begin
      reg_wr(lsq_pkg::ADDR_SS_CTRL, {2'b00, 4'(s), 2'b01});
      clk_n(3);
      `CHK(o_pgd_src, exp_src(4'(s)))
    end
    i_en_src_sel = 1'b1;
    clk_n(4);
    `CHK(o_pgd_active, 1'b0)
    i_en_src_sel = 1'b0;
    for (int run = 0; run < 2; run++) begin
      for (int r = 0; r < 8; r++) pr[r] = 4'($random(seed));
      if (run == 0) begin
        pr[0] = lsq_pkg::PRIO_FIRST;
        pr[7] = lsq_pkg::PRIO_LAST;
        pr[1] = 4'hd;
        pr[2] = lsq_pkg::PRIO_OFF;
      end
      set_prio();
      reg_wr(lsq_pkg::ADDR_SS_CTRL, 8'h00);
      clk_n(3);
      `CHK(o_pgd_src, exp_src(4'h0))
      i_pwr_req = 1'b1;
      for (int k = 1; k <= 12; k++) begin
        clk_n(k == 1 ? 54 : 100);
        `CHK(o_reg_en, exp_en(k))
      end
      clk_n(100);
      `CHK(o_seq_on, 1'b1)
      i_pwr_req = 1'b0;
      for (int k = 12; k >= 1; k--) begin
        clk_n(k == 12 ? 54 : 100);
        `CHK(o_reg_en, exp_en(k - 1))
      end
      clk_n(100);
      `CHK(o_seq_busy, 1'b0)
    end
    end_sim();
  end
endmodule

bind lsq_seq_cfg lsq_seq_cfg_asserts u_chk (
  .i_clk(i_clk), .i_rst(i_rst), .i_ce(i_ce),
  .i_en_src_sel(i_en_src_sel),
  .o_reg_en(o_reg_en), .o_seq_busy(o_seq_busy), .o_seq_on(o_seq_on),
  .o_pgd_src(o_pgd_src), .o_pgd_active(o_pgd_active)
);
`default_nettype wire
